/* hw/pwdt_pkg.sv */
package pwdt_pkg;
  // ------------------------------------------------------------
  // register map
  // ------------------------------------------------------------
  localparam logic [7:0] PWDT_CTRL_OFFSET = 8'h0c;
  localparam logic [15:0] PWDT_CTRL_RESET = 16'h6904;
  localparam logic [7:0] PWDT_WRITE_KEY = 8'h5a;
  localparam logic [7:0] PWDT_READ_KEY = 8'h69;
  // ------------------------------------------------------------
  // field positions
  // ------------------------------------------------------------
  localparam int PWDT_FREEZE_BIT = 7;
  localparam int PWDT_SRC_LSB = 5;
  localparam int PWDT_MODE_BIT = 4;
  localparam int PWDT_RESTART_BIT = 3;
  localparam int PWDT_PERIOD_LSB = 0;
  // ------------------------------------------------------------
  // tick sources
  // ------------------------------------------------------------
  localparam logic [1:0] PWDT_SRC_SUB = 2'h0;
  localparam logic [1:0] PWDT_SRC_AUX = 2'h1;
  localparam logic [1:0] PWDT_SRC_VLO = 2'h2;
  localparam logic [1:0] PWDT_SRC_EXTRA = 2'h3;
  // ------------------------------------------------------------
  // counter taps per period code 0..7
  // ------------------------------------------------------------
  localparam int PWDT_CNT_W = 32;
  // a tap falls once every 2^(tap+1) ticks, so divide by 2^n taps bit n-1
  localparam int PWDT_TAP0 = 30;
  localparam int PWDT_TAP1 = 26;
  localparam int PWDT_TAP2 = 22;
  localparam int PWDT_TAP3 = 18;
  localparam int PWDT_TAP4 = 14;
  localparam int PWDT_TAP5 = 12;
  localparam int PWDT_TAP6 = 8;
  localparam int PWDT_TAP7 = 5;

  typedef struct packed {
    logic counter_freeze;
    logic [1:0] tick_source_select;
    logic interval_mode_select;
    logic [2:0] period_select;
  } pwdt_ctrl_t;

  typedef struct packed {
    logic sub_tick;
    logic aux_tick;
    logic vlo_tick;
    logic extra_tick;
  } pwdt_ticks_t;

  typedef enum logic [1:0] {
    PWDT_ACC_NONE = 2'b01,
    PWDT_ACC_WORD = 2'b10
  } pwdt_acc_t;
endpackage

/* hw/pwdt_top.sv */
// The strobed register port was left to the implementer.
`timescale 1ns/1ps
// Notes on behaviour
// [R1] after reset: watchdog mode, subsystem clock, ~32 ms
// [R2] software writes full words with key
// [R3] wrong key on write forces soft reset
// [R4] reads return 069h in upper byte
// [R5] byte read returns low byte
// [R6] byte write forces soft reset
// [R7] 32-bit counter hidden from software
// [R8] source field selects one of four ticks
// [R9] watchdog expiry forces soft reset
// [R10] mode bit: 0 watchdog, 1 interval
// [R11] interval expiry sets flag, no reset
// [R12] interrupt needs flag, enable and global enable
// [R13] flag clears on service or software
// [R14] flag and enable bit 0 of outside registers
// [R15] flag set after reset caused here
// [R16] watchdog mode: failed source replaced by low osc
// [R17] interval mode: failed source stops counting
// [R18] freeze bit stops the counter
// [R19] period field selects counter tap
// [R20] software must service before first expiry
// [R21] change period together with restart
// [R22] freeze before changing source
// [R23] restart bit clears counter, reads zero
// [R24] period code 111 taps divide by 64
module pwdt_top
  import pwdt_pkg::*;
#(
  parameter int CNT_W = PWDT_CNT_W
) (
  input wire logic CLOCK,
  input wire logic SYS_RST,
  input wire logic CLK_EN,
  input wire logic [7:0] ADDR,
  input wire logic [15:0] WDATA,
  input wire logic WR_STB,
  input wire logic RD_STB,
  input wire logic BYTE_ACC,
  input wire logic [15:0] RDATA_DUMMY_UNUSED_NONE,
  output logic [15:0] RDATA,
  input wire pwdt_ticks_t TICKS,
  input wire logic SUB_CLK_FAIL,
  input wire logic AUX_CLK_FAIL,
  input wire logic TIMER_CAUSED_RESET,
  input wire logic INTERVAL_IRQ_ENABLE,
  input wire logic GLOBAL_IRQ_ENABLE,
  input wire logic IRQ_SERVICED,
  input wire logic FLAG_SW_CLEAR,
  output logic SOFT_SYSTEM_RESET,
  output logic TIMEOUT_FLAG,
  output logic INTERVAL_IRQ,
  output logic CLOCK_REQUEST
);
  // ------------------------------------------------------------
  // helpers
  // ------------------------------------------------------------
  function automatic int tap_of(input logic [2:0] code);
    case (code)
      3'h0: tap_of = PWDT_TAP0;
      3'h1: tap_of = PWDT_TAP1;
      3'h2: tap_of = PWDT_TAP2;
      3'h3: tap_of = PWDT_TAP3;
      3'h4: tap_of = PWDT_TAP4;
      3'h5: tap_of = PWDT_TAP5;
      3'h6: tap_of = PWDT_TAP6;
      default: tap_of = PWDT_TAP7;
    endcase
  endfunction

  // ------------------------------------------------------------
  // control register and access decode
  // ------------------------------------------------------------
  pwdt_ctrl_t ctrl_q, ctrl_d;
  logic [CNT_W-1:0] cnt_q, cnt_d;
  logic flag_q, flag_d;
  logic reset_q, reset_d;
  logic [15:0] rdata_q, rdata_d;
  logic hit, key_ok, wr_ok, wr_bad, restart, tick, expire, tap_now, tap_prev_q, tap_prev_d;
  logic [1:0] eff_src;
  logic [7:0] low_byte;
  pwdt_acc_t acc;

  assign hit = (ADDR == PWDT_CTRL_OFFSET);
  assign acc = BYTE_ACC ? PWDT_ACC_NONE : PWDT_ACC_WORD;
  assign key_ok = (WDATA[15:8] == PWDT_WRITE_KEY);
  assign wr_ok = WR_STB && hit && acc == PWDT_ACC_WORD && key_ok;
  // byte writes and wrong keys both reset, whatever the mode
  assign wr_bad = WR_STB && hit && (acc == PWDT_ACC_NONE || !key_ok); // [R3] [R6]
  assign restart = wr_ok && WDATA[PWDT_RESTART_BIT]; // [R23] [R21]
  assign low_byte = {ctrl_q.counter_freeze, ctrl_q.tick_source_select,
                     ctrl_q.interval_mode_select, 1'b0, ctrl_q.period_select};

  // ------------------------------------------------------------
  // tick selection with fail-safe
  // ------------------------------------------------------------
  always_comb begin
    eff_src = ctrl_q.tick_source_select; // [R8]
    if (!ctrl_q.interval_mode_select &&
        ((eff_src == PWDT_SRC_SUB && SUB_CLK_FAIL) ||
         (eff_src == PWDT_SRC_AUX && AUX_CLK_FAIL))) begin
      eff_src = PWDT_SRC_VLO; // [R16]
    end
    unique case (eff_src)
      PWDT_SRC_SUB: tick = TICKS.sub_tick && !SUB_CLK_FAIL; // [R17]
      PWDT_SRC_AUX: tick = TICKS.aux_tick && !AUX_CLK_FAIL;
      PWDT_SRC_VLO: tick = TICKS.vlo_tick;
      PWDT_SRC_EXTRA: tick = TICKS.extra_tick;
    endcase
  end
  // keeps the source alive in low-power modes while guarding
  assign CLOCK_REQUEST = !ctrl_q.interval_mode_select && !ctrl_q.counter_freeze; // [R16]

  // ------------------------------------------------------------
  // counter and expiry
  // ------------------------------------------------------------
  assign tap_now = cnt_q[tap_of(ctrl_q.period_select)]; // [R19] [R24]
  // expiry is the falling edge of the tap, i.e. every 2^(tap+1) ticks
  assign expire = tap_prev_q && !tap_now;

  always_comb begin
    ctrl_d = ctrl_q;
    cnt_d = cnt_q;
    tap_prev_d = tap_now;
    flag_d = flag_q;
    reset_d = 1'b0;
    rdata_d = 16'h0000;
    if (RD_STB && hit) begin
      rdata_d = (acc == PWDT_ACC_NONE) ? {8'h00, low_byte} // [R5]
                                       : {PWDT_READ_KEY, low_byte}; // [R4] [R23]
    end
    if (wr_ok) begin
      ctrl_d.counter_freeze = WDATA[PWDT_FREEZE_BIT];
      ctrl_d.tick_source_select = WDATA[PWDT_SRC_LSB+:2];
      ctrl_d.interval_mode_select = WDATA[PWDT_MODE_BIT]; // [R10]
      ctrl_d.period_select = WDATA[PWDT_PERIOD_LSB+:3];
    end
    if (restart) begin
      cnt_d = '0; // [R23]
      tap_prev_d = 1'b0;
    end else if (tick && !ctrl_q.counter_freeze) begin // [R18] [R7]
      cnt_d = cnt_q + 1'b1;
    end
    if (IRQ_SERVICED || FLAG_SW_CLEAR) begin
      flag_d = 1'b0; // [R13]
    end
    if (expire && ctrl_q.interval_mode_select) begin
      flag_d = 1'b1; // [R11]
    end
    if (wr_bad || (expire && !ctrl_q.interval_mode_select)) begin
      reset_d = 1'b1; // [R9] [R3]
    end
  end

  // ------------------------------------------------------------
  // registers
  // ------------------------------------------------------------
  always_ff @(posedge CLOCK) begin
    if (SYS_RST) begin
      ctrl_q <= pwdt_ctrl_t'(PWDT_CTRL_RESET[7:0] & 8'hf7); // [R1]
      cnt_q <= '0;
      tap_prev_q <= 1'b0;
      flag_q <= 1'b0;
      reset_q <= 1'b0;
      rdata_q <= 16'h0000;
    end else if (CLK_EN) begin
      ctrl_q <= ctrl_d;
      cnt_q <= cnt_d;
      tap_prev_q <= tap_prev_d;
      flag_q <= flag_d;
      reset_q <= reset_d;
      rdata_q <= rdata_d;
    end
  end

  // watchdog-mode flag is the reset cause recorded outside
  assign TIMEOUT_FLAG = flag_q || TIMER_CAUSED_RESET; // [R15] [R14]
  assign INTERVAL_IRQ = ctrl_q.interval_mode_select && flag_q &&
                        INTERVAL_IRQ_ENABLE && GLOBAL_IRQ_ENABLE; // [R12]
  assign SOFT_SYSTEM_RESET = reset_q;
  assign RDATA = rdata_q;

  // ------------------------------------------------------------
  // assertions
  // ------------------------------------------------------------
  default clocking cb @(posedge CLOCK); endclocking
  default disable iff (SYS_RST);

  a_bad_key_reset: assert property (CLK_EN && wr_bad |=> SOFT_SYSTEM_RESET) // [R3]
    else $error("bad key write did not reset");
  a_read_key: assert property (CLK_EN && RD_STB && hit && !BYTE_ACC |=>
      RDATA[15:8] == PWDT_READ_KEY) // [R4]
    else $error("read key wrong");
  a_byte_read: assert property (CLK_EN && RD_STB && hit && BYTE_ACC |=>
      RDATA == {8'h00, $past(low_byte)}) // [R5]
    else $error("byte read wrong");
  a_restart_zero: assert property (CLK_EN && restart |=> cnt_q == '0) // [R23]
    else $error("restart did not clear counter");
  a_freeze_hold: assert property (CLK_EN && ctrl_q.counter_freeze && !restart |=>
      $stable(cnt_q)) // [R18]
    else $error("frozen counter moved");
  a_interval_noreset: assert property (CLK_EN && expire && ctrl_q.interval_mode_select &&
      !wr_bad |=> !SOFT_SYSTEM_RESET && flag_q) // [R11]
    else $error("interval expiry misbehaved");
  a_wd_expire_reset: assert property (CLK_EN && expire && !ctrl_q.interval_mode_select |=>
      SOFT_SYSTEM_RESET) // [R9]
    else $error("watchdog expiry missed");
  a_irq_gate: assert property (INTERVAL_IRQ |-> flag_q && INTERVAL_IRQ_ENABLE &&
      GLOBAL_IRQ_ENABLE) // [R12]
    else $error("irq without enables");
  a_failsafe_src: assert property (!ctrl_q.interval_mode_select && SUB_CLK_FAIL &&
      ctrl_q.tick_source_select == PWDT_SRC_SUB |-> eff_src == PWDT_SRC_VLO) // [R16]
    else $error("fail-safe not applied");
  a_reset_default: assert property ($fell(SYS_RST) |-> !ctrl_q.interval_mode_select &&
      ctrl_q.tick_source_select == PWDT_SRC_SUB && ctrl_q.period_select == 3'h4) // [R1]
    else $error("reset defaults wrong");

  c_wd_expire: cover property (expire && !ctrl_q.interval_mode_select);
  c_interval_irq: cover property (INTERVAL_IRQ);
  c_key_viol: cover property (wr_bad);
  c_restart: cover property (restart);
endmodule

/* verif/tb_top.sv */
`timescale 1ns/1ps
module tb_top
  import pwdt_pkg::*;
;
  // ------------------------------------------------------------
  // stimulus and observation
  // ------------------------------------------------------------
  logic CLOCK = 1'b0;
  logic SYS_RST = 1'b1;
  logic CLK_EN = 1'b1;
  logic WR_STB = 1'b0;
  logic RD_STB = 1'b0;
  logic BYTE_ACC = 1'b0;
  logic [7:0] ADDR = 8'h00;
  logic [15:0] WDATA = 16'h0000;
  logic [15:0] RDATA;
  logic SUB_CLK_FAIL = 1'b0;
  logic AUX_CLK_FAIL = 1'b0;
  logic TIMER_CAUSED_RESET = 1'b0;
  logic INTERVAL_IRQ_ENABLE = 1'b0;
  logic GLOBAL_IRQ_ENABLE = 1'b0;
  logic IRQ_SERVICED = 1'b0;
  logic FLAG_SW_CLEAR = 1'b0;
  logic SOFT_SYSTEM_RESET, TIMEOUT_FLAG, INTERVAL_IRQ, CLOCK_REQUEST;
  pwdt_ticks_t TICKS = '0;
  logic [3:0] tick_mask = 4'h0;
  logic [15:0] rv;
  int num_errors = 0;
  int comparisons = 0;
  int cycles = 0;
  int rst_cnt = 0;
  int n, r0;

  pwdt_top dut_u (.CLOCK(CLOCK), .SYS_RST(SYS_RST), .CLK_EN(CLK_EN), .ADDR(ADDR),
    .WDATA(WDATA), .WR_STB(WR_STB), .RD_STB(RD_STB), .BYTE_ACC(BYTE_ACC),
    .RDATA_DUMMY_UNUSED_NONE(16'h0000), .RDATA(RDATA), .TICKS(TICKS),
    .SUB_CLK_FAIL(SUB_CLK_FAIL), .AUX_CLK_FAIL(AUX_CLK_FAIL),
    .TIMER_CAUSED_RESET(TIMER_CAUSED_RESET), .INTERVAL_IRQ_ENABLE(INTERVAL_IRQ_ENABLE),
    .GLOBAL_IRQ_ENABLE(GLOBAL_IRQ_ENABLE), .IRQ_SERVICED(IRQ_SERVICED),
    .FLAG_SW_CLEAR(FLAG_SW_CLEAR), .SOFT_SYSTEM_RESET(SOFT_SYSTEM_RESET),
    .TIMEOUT_FLAG(TIMEOUT_FLAG), .INTERVAL_IRQ(INTERVAL_IRQ), .CLOCK_REQUEST(CLOCK_REQUEST));

  always #2.5 CLOCK = ~CLOCK;

  // ticks every cycle keep the 64-tick period short
  always @(posedge CLOCK) begin
    TICKS <= pwdt_ticks_t'(tick_mask);
    cycles <= cycles + 1;
    if (SOFT_SYSTEM_RESET === 1'b1) begin
      rst_cnt <= rst_cnt + 1;
    end
    if (cycles == 20000) begin
      num_errors++;
      stop_test();
    end
  end

  // ------------------------------------------------------------
  // tasks
  // ------------------------------------------------------------
  task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
    comparisons++;
    if (seen !== exp) begin
      num_errors++;
      $display("[ERR] t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask

  task automatic wr(input logic [15:0] d, input logic b);
    @(posedge CLOCK);
    ADDR <= PWDT_CTRL_OFFSET;
    WDATA <= d;
    WR_STB <= 1'b1;
    BYTE_ACC <= b;
    @(posedge CLOCK);
    WR_STB <= 1'b0;
    BYTE_ACC <= 1'b0;
  endtask

  task automatic rd(input logic [7:0] a, input logic b, output logic [15:0] d);
    @(posedge CLOCK);
    ADDR <= a;
    RD_STB <= 1'b1;
    BYTE_ACC <= b;
    @(posedge CLOCK);
    RD_STB <= 1'b0;
    BYTE_ACC <= 1'b0;
    #1 d = RDATA;
  endtask

  // bounded wait on the reset pulse (sel 0) or the flag (sel 1)
  task automatic wait_for(input logic sel, input int max, output int cnt);
    cnt = 0;
    // look only once the edge that launched the pulse has settled
    #1;
    while (cnt < max && ((sel ? TIMEOUT_FLAG : SOFT_SYSTEM_RESET) !== 1'b1)) begin
      @(posedge CLOCK);
      #1 cnt++;
    end
  endtask

  task automatic do_reset(input int len);
    @(posedge CLOCK);
    SYS_RST <= 1'b1;
    repeat (len) @(posedge CLOCK);
    SYS_RST <= 1'b0;
  endtask

  task automatic stop_test();
    $display("num_errors=%0d comparisons=%0d", num_errors, comparisons);
    if (num_errors == 0 && comparisons > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask

  // ------------------------------------------------------------
  // sequence
  // ------------------------------------------------------------
  initial begin
    do_reset(12);
    rd(PWDT_CTRL_OFFSET, 1'b0, rv);
    chk(rv, PWDT_CTRL_RESET);
    chk({15'h0, CLOCK_REQUEST}, 16'h0001);
    rd(8'h0d, 1'b0, rv);
    chk(rv, 16'h0000);
    wr(16'h5a0f, 1'b0);
    rd(PWDT_CTRL_OFFSET, 1'b0, rv);
    chk(rv, 16'h6907);
    rd(PWDT_CTRL_OFFSET, 1'b1, rv);
    chk(rv, 16'h0007);
    // failed subsystem clock: only the low oscillator ticks
    SUB_CLK_FAIL <= 1'b1;
    tick_mask <= 4'b0010;
    wr(16'h5a0f, 1'b0);
    wait_for(1'b0, 300, n);
    chk({15'h0, (n >= 56 && n <= 72)}, 16'h0001);
    do_reset(2);
    SUB_CLK_FAIL <= 1'b0;
    tick_mask <= 4'h0;
    rd(PWDT_CTRL_OFFSET, 1'b0, rv);
    chk(rv, PWDT_CTRL_RESET);
    // bad key in both modes, then a keyed byte write
    for (int i = 0; i < 3; i++) begin
      if (i == 1) begin
        wr(16'h5a9f, 1'b0);
      end
      wr((i == 2) ? 16'h5a0f : 16'h5b0f, i == 2);
      wait_for(1'b0, 4, n);
      chk({15'h0, n < 4}, 16'h0001);
      do_reset(2);
    end
    tick_mask <= 4'b1000;
    wr(16'h5a8f, 1'b0);
    #1 chk({15'h0, CLOCK_REQUEST}, 16'h0000);
    wait_for(1'b0, 300, n);
    chk(16'(n), 16'd300);
    // interval mode on each tick source
    r0 = rst_cnt;
    for (int s = 0; s < 4; s++) begin
      wr(16'h5a9f, 1'b0);
      tick_mask <= 4'b1000 >> s;
      wr({8'h5a, 1'b0, s[1:0], 1'b1, 1'b1, 3'h7}, 1'b0);
      wait_for(1'b1, 300, n);
      chk({15'h0, (n >= 56 && n <= 72)}, 16'h0001);
      for (int j = 0; j < 4; j++) begin
        INTERVAL_IRQ_ENABLE <= j[0];
        GLOBAL_IRQ_ENABLE <= j[1];
        @(posedge CLOCK);
        #1 chk({15'h0, INTERVAL_IRQ}, {15'h0, j == 3});
      end
      @(posedge CLOCK);
      IRQ_SERVICED <= s[0];
      FLAG_SW_CLEAR <= ~s[0];
      @(posedge CLOCK);
      IRQ_SERVICED <= 1'b0;
      FLAG_SW_CLEAR <= 1'b0;
      #1 chk({15'h0, TIMEOUT_FLAG}, 16'h0000);
    end
    chk(16'(rst_cnt - r0), 16'h0000);
    // failed auxiliary source in interval mode is not replaced
    AUX_CLK_FAIL <= 1'b1;
    tick_mask <= 4'b0100;
    wr(16'h5a3f, 1'b0);
    wait_for(1'b1, 300, n);
    chk(16'(n), 16'd300);
    TIMER_CAUSED_RESET <= 1'b1;
    do_reset(2);
    #1 chk({15'h0, TIMEOUT_FLAG}, 16'h0001);
    stop_test();
  end
endmodule
